/* pkg/rsc_spi_regs.svh */
/*
 * Constants of the clock-calendar serial command front end: instruction codes,
 * address map, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef RSC_SPI_REGS_SVH
`define RSC_SPI_REGS_SVH

// Instruction codes
`define RSC_CMD_NVM_READ      8'h03
`define RSC_CMD_NVM_WRITE     8'h02
`define RSC_CMD_LATCH_CLEAR   8'h04
`define RSC_CMD_LATCH_SET     8'h06
`define RSC_CMD_STATUS_READ   8'h05
`define RSC_CMD_STATUS_WRITE  8'h01
`define RSC_CMD_RTC_READ      8'h13
`define RSC_CMD_RTC_WRITE     8'h12
`define RSC_CMD_ID_UNLOCK     8'h14
`define RSC_CMD_ID_WRITE      8'h32
`define RSC_CMD_ID_READ       8'h33
`define RSC_CMD_WDT_CLEAR     8'h44
`define RSC_CMD_RAM_CLEAR     8'h54

// Address map of the clock and SRAM space; nonvolatile, ID and page sizes
`define RSC_RTC_LAST          8'h1F
`define RSC_SRAM_FIRST        8'h20
`define RSC_SRAM_LAST         8'h5F
`define RSC_RTC_DEPTH         96
`define RSC_NVM_DEPTH         256
`define RSC_ID_DEPTH          8
`define RSC_PAGE_BYTES        8

// Register addresses and bit positions
`define RSC_ADDR_BACKUP       7'h04
`define RSC_BIT_BACKUP_EN     3
`define RSC_ADDR_WATCHDOG     7'h0A
`define RSC_BIT_WDT_PULSE     4
`define RSC_BIT_WDT_FLAG      6
`define RSC_ADDR_EVENT        7'h0B
`define RSC_BIT_EV_FAST_FLAG  7
`define RSC_BIT_EV_SLOW_FLAG  6
`define RSC_ADDR_ALARM0_DAY   7'h0F
`define RSC_ADDR_ALARM1_DAY   7'h16
`define RSC_BIT_ALARM_FLAG    3

// Status register fields and reset value
`define RSC_STAT_WIP          0
`define RSC_STAT_WEL          1
`define RSC_STAT_BP_LO        2
`define RSC_STAT_BP_HI        3
`define RSC_STAT_RESET        8'h00

// Timing
`define RSC_CLK_KHZ           40000
`define RSC_WRITE_TIME_MS     5
`define RSC_WRITE_CYCLES      (`RSC_WRITE_TIME_MS * `RSC_CLK_KHZ)
`define RSC_WDO_SHORT_CYCLES  256
`define RSC_WDO_LONG_CYCLES   2048

`endif

/* pkg/rsc_pkg.sv */
/*
 * Types of the clock-calendar serial command front end.
 * Assumes nothing beyond the constants header.
 */
`include "rsc_spi_regs.svh"

package rsc_pkg;

	// Phase of the serial transfer
	typedef enum logic [3:0] {
		PH_INSTR  = 4'b0001,
		PH_ADDR   = 4'b0010,
		PH_DATA   = 4'b0100,
		PH_IGNORE = 4'b1000
	} rsc_phase_type;

	// Operation chosen by the instruction byte
	typedef enum logic [8:0] {
		OP_NONE     = 9'b0_0000_0001,
		OP_NVM_RD   = 9'b0_0000_0010,
		OP_NVM_WR   = 9'b0_0000_0100,
		OP_RTC_RD   = 9'b0_0000_1000,
		OP_RTC_WR   = 9'b0_0001_0000,
		OP_ID_RD    = 9'b0_0010_0000,
		OP_ID_WR    = 9'b0_0100_0000,
		OP_STAT_RD  = 9'b0_1000_0000,
		OP_STAT_WR  = 9'b1_0000_0000
	} rsc_op_type;

endpackage

/* hdl/rsc_spi_cmd.sv */
/*
 * Serial command front end of a clock-calendar: instruction decode, address
 * pointer, clock/SRAM, nonvolatile, ID and status storage, watchdog pulse
 * and shared interrupt pins.
 * Assumes the serial pins arrive asynchronously and are sampled by ref_clk,
 * whose rate is well above four times the serial clock rate.
 */
// Notes on behaviour
// - Chip select low selects; high deselects and enters standby.
// - A started write cycle completes; standby only after it ends.
// - Serial output is high impedance whenever deselected.
// - Chip select rising after a valid write sequence starts the write cycle.
// - Input sampled on serial clock rise; output changes after its fall.
// - First rising serial clock after select samples the first bit.
// - Bytes travel MSB first into an 8-bit instruction register.
// - Decode nonvolatile read 03h and write 02h from selected address.
// - Decode latch clear 04h, latch set 06h, status read 05h, write 01h.
// - Decode clock/SRAM read 13h and write 12h from selected address.
// - Decode ID unlock 14h, ID write 32h, ID read 33h.
// - 44h clears the watchdog; 54h clears the RAM locations to zero.
// - Read is instruction, address, then data shifted out on output.
// - Pointer steps to next address after each byte shifted out.
// - Sequential read wraps past highest address to first valid one.
// - Raising chip select ends a read and stops shifting.
// - Clock registers 00h-1Fh, SRAM 20h-5Fh; unused addresses inaccessible.
// - Time/date at 00h-07h read/write; configuration at 08h-0Bh.
// - Alarm 0 at 0Ch-11h, alarm 1 at 12h-17h, stamps at 18h-1Fh.
// - Watchdog overflow pulses the open-drain output; length from 0Ah bit 4.
// - Interrupt pin low on event or alarm until software clears flag.
// - Latch set needs a chip select rise or later writes are ignored.
// - Latch clears at reset and after latch clear or completed writes.
// - Nonvolatile write takes up to 8 bytes, wrapping within its page.
// - Access started in clock space wraps within 00h-1Fh.
`include "rsc_spi_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module rsc_spi_cmd #(
	parameter int unsigned WRITE_CYCLES = `RSC_WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Serial pins
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	output logic      so_out,
	output logic      so_oe,
	// Events from the calendar, alarm, detector and watchdog logic
	input  wire logic alarm0_match,
	input  wire logic alarm1_match,
	input  wire logic fast_event_hit,
	input  wire logic slow_event_hit,
	input  wire logic watchdog_overflow,
	// Open-drain pins, output level always low
	output logic      watchdog_pulse_out,
	output logic      watchdog_pulse_oe,
	output logic      irq_n_out,
	output logic      irq_n_oe,
	// Status and side effects
	output logic      standby,
	output logic      write_busy,
	output logic      watchdog_clear,
	output logic      backup_enable_bit
);
	import rsc_pkg::*;

	// Input synchronisers and edge history
	logic [2:0] cs_sync;
	logic [2:0] sck_sync;
	logic [1:0] si_sync;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_sync  <= 3'b111;
			sck_sync <= 3'b000;
			si_sync  <= 2'b00;
		end else begin
			cs_sync  <= {cs_sync[1:0], cs_n};
			sck_sync <= {sck_sync[1:0], sck};
			si_sync  <= {si_sync[0], si};
		end
	end

	logic selected;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	assign selected = ~cs_sync[1];
	assign cs_rise  = cs_sync[1] & ~cs_sync[2];
	assign sck_rise = selected & sck_sync[1] & ~sck_sync[2];
	assign sck_fall = selected & ~sck_sync[1] & sck_sync[2];

	// Transfer state
	rsc_phase_type phase;
	rsc_op_type    op;
	logic [2:0]    bit_cnt;
	logic [7:0]    shift;
	logic [7:0]    tx;
	logic [7:0]    ptr;
	logic [7:0]    status;
	logic          wel;
	logic          wip;
	logic [7:0]    byte_in;
	logic          byte_done;
	logic          instr_done;
	assign byte_in    = {shift[6:0], si_sync[1]};
	assign byte_done  = sck_rise & (bit_cnt == 3'd7) & (phase != PH_IGNORE);
	assign instr_done = byte_done & (phase == PH_INSTR);

	// Storage
	logic [7:0] rtc_mem [0:`RSC_RTC_DEPTH-1];
	logic [7:0] nvm_mem [0:`RSC_NVM_DEPTH-1];
	logic [7:0] id_mem  [0:`RSC_ID_DEPTH-1];

	// Next pointer value for each address space
	function automatic logic [7:0] next_ptr(input rsc_op_type o, input logic [7:0] a);
		logic [7:0] n;
		n = a + 8'h01;
		case (o)
			OP_RTC_RD, OP_RTC_WR: begin
				if (a <= `RSC_RTC_LAST)
					n = {3'b000, a[4:0] + 5'd1};
				else if (a == `RSC_SRAM_LAST)
					n = `RSC_SRAM_FIRST;
			end
			OP_NVM_WR: n = {a[7:3], a[2:0] + 3'd1};
			OP_ID_RD, OP_ID_WR: n = {5'd0, a[2:0] + 3'd1};
			default: n = a + 8'h01;
		endcase
		return n;
	endfunction

	// Byte presented for the read at the address being looked at
	logic [7:0] look_addr;
	logic [7:0] rd_byte;
	assign look_addr = (phase == PH_ADDR) ? byte_in : ptr;
	always_comb begin
		rd_byte = 8'h00;
		case (op)
			OP_NVM_RD: rd_byte = nvm_mem[look_addr];
			OP_RTC_RD: begin
				if (look_addr <= `RSC_SRAM_LAST)
					rd_byte = rtc_mem[look_addr[6:0]];
			end
			OP_ID_RD:   rd_byte = id_mem[look_addr[2:0]];
			OP_STAT_RD: rd_byte = status;
			default:    rd_byte = 8'h00;
		endcase
	end

	logic is_read;
	assign is_read = (op == OP_NVM_RD) | (op == OP_RTC_RD) | (op == OP_ID_RD) | (op == OP_STAT_RD);

	// Instruction decode, address capture and data shifting
	always_ff @(posedge ref_clk) begin
		if (rst || !selected) begin
			phase   <= PH_INSTR;
			op      <= OP_NONE;
			bit_cnt <= 3'd0;
			shift   <= 8'h00;
			tx      <= 8'h00;
			ptr     <= 8'h00;
			so_out  <= 1'b0;
			so_oe   <= 1'b0;
		end else begin
			if (sck_rise && phase != PH_IGNORE) begin
				shift   <= byte_in;
				bit_cnt <= bit_cnt + 3'd1;
			end
			if (instr_done) begin
				phase <= PH_IGNORE;
				op    <= OP_NONE;
				if (!wip || byte_in == `RSC_CMD_STATUS_READ) begin
					case (byte_in)
						`RSC_CMD_NVM_READ: begin
							op <= OP_NVM_RD;
							phase <= PH_ADDR;
						end
						`RSC_CMD_NVM_WRITE: begin
							op <= OP_NVM_WR;
							phase <= PH_ADDR;
						end
						`RSC_CMD_RTC_READ: begin
							op <= OP_RTC_RD;
							phase <= PH_ADDR;
						end
						`RSC_CMD_RTC_WRITE: begin
							op <= OP_RTC_WR;
							phase <= PH_ADDR;
						end
						`RSC_CMD_ID_READ: begin
							op <= OP_ID_RD;
							phase <= PH_ADDR;
						end
						`RSC_CMD_ID_WRITE: begin
							op <= OP_ID_WR;
							phase <= PH_ADDR;
						end
						`RSC_CMD_STATUS_READ: begin
							op <= OP_STAT_RD;
							phase <= PH_DATA;
							tx <= status;
						end
						`RSC_CMD_STATUS_WRITE: begin
							op <= OP_STAT_WR;
							phase <= PH_DATA;
						end
						default: phase <= PH_IGNORE;
					endcase
				end
			end else if (byte_done && phase == PH_ADDR) begin
				phase <= PH_DATA;
				ptr   <= is_read ? next_ptr(op, byte_in) : byte_in;
				tx    <= rd_byte;
			end else if (byte_done && phase == PH_DATA) begin
				ptr <= next_ptr(op, ptr);
				if (is_read)
					tx <= rd_byte;
			end
			// Output changes only after a falling serial clock
			if (sck_fall && phase == PH_DATA && is_read) begin
				so_out <= tx[7];
				so_oe  <= 1'b1;
				tx     <= {tx[6:0], 1'b0};
			end
		end
	end

	// Page staging for nonvolatile, ID and status writes
	logic [7:0] stage [0:`RSC_PAGE_BYTES-1];
	logic [7:0] stage_mask;
	logic [7:0] stage_base;
	logic       stage_ok;
	logic       staged_write;
	logic       commit;
	assign staged_write = (op == OP_NVM_WR) | (op == OP_ID_WR) | (op == OP_STAT_WR);
	// Valid only when the select rises on a byte boundary after data
	assign commit = cs_rise & staged_write & stage_ok & wel & (bit_cnt == 3'd0);

	always_ff @(posedge ref_clk) begin
		if (rst || instr_done) begin
			stage_mask <= 8'h00;
			stage_ok   <= 1'b0;
			stage_base <= 8'h00;
		end else if (byte_done && phase == PH_ADDR) begin
			stage_base <= {byte_in[7:3], 3'b000};
		end else if (byte_done && phase == PH_DATA && staged_write) begin
			stage[ptr[2:0]]        <= byte_in;
			stage_mask[ptr[2:0]]   <= 1'b1;
			stage_ok               <= 1'b1;
		end
	end

	// Write latch, unlock, latch-set pending and write-cycle timer
	logic        latch_set_pend;
	logic        id_unlocked;
	logic [31:0] wip_cnt;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wel            <= 1'b0;
			latch_set_pend <= 1'b0;
			id_unlocked    <= 1'b0;
			wip            <= 1'b0;
			wip_cnt        <= 32'h0000_0000;
			status         <= `RSC_STAT_RESET;
		end else begin
			if (instr_done && !wip && byte_in == `RSC_CMD_LATCH_SET)
				latch_set_pend <= 1'b1;
			else if (cs_rise)
				latch_set_pend <= 1'b0;
			if (instr_done && !wip && byte_in == `RSC_CMD_ID_UNLOCK)
				id_unlocked <= 1'b1;
			if (cs_rise && latch_set_pend)
				wel <= 1'b1;
			else if (instr_done && !wip && byte_in == `RSC_CMD_LATCH_CLEAR)
				wel <= 1'b0;
			else if (commit)
				wel <= 1'b0;
			if (commit) begin
				wip     <= 1'b1;
				wip_cnt <= WRITE_CYCLES;
				if (op == OP_STAT_WR && stage_mask[0])
					status[`RSC_STAT_BP_HI:`RSC_STAT_BP_LO] <= stage[0][3:2];
				if (op == OP_ID_WR)
					id_unlocked <= 1'b0;
			end else if (wip) begin
				if (wip_cnt <= 32'h0000_0001)
					wip <= 1'b0;
				wip_cnt <= wip_cnt - 32'h0000_0001;
			end
			status[`RSC_STAT_WIP] <= wip;
			status[`RSC_STAT_WEL] <= wel;
		end
	end

	// Array updates on commit; ID writes need a prior unlock
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < `RSC_PAGE_BYTES; i++) begin
			if (commit && stage_mask[i] && op == OP_NVM_WR)
				nvm_mem[stage_base + 8'(i)] <= stage[i];
			if (commit && stage_mask[i] && op == OP_ID_WR && id_unlocked)
				id_mem[i] <= stage[i];
		end
	end

	// Clock and SRAM space: serial writes, RAM clear and event flags
	logic ram_clear;
	logic rtc_wr;
	assign ram_clear = instr_done & ~wip & (byte_in == `RSC_CMD_RAM_CLEAR);
	assign rtc_wr = byte_done & (phase == PH_DATA) & (op == OP_RTC_WR) & (ptr <= `RSC_SRAM_LAST);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < `RSC_RTC_DEPTH; i++)
				rtc_mem[i] <= 8'h00;
		end else begin
			if (ram_clear) begin
				for (int i = 32; i < `RSC_RTC_DEPTH; i++)
					rtc_mem[i] <= 8'h00;
			end else if (rtc_wr) begin
				rtc_mem[ptr[6:0]] <= byte_in;
			end
			// Flags set after the write so a set wins over a clear
			if (alarm0_match)
				rtc_mem[`RSC_ADDR_ALARM0_DAY][`RSC_BIT_ALARM_FLAG] <= 1'b1;
			if (alarm1_match)
				rtc_mem[`RSC_ADDR_ALARM1_DAY][`RSC_BIT_ALARM_FLAG] <= 1'b1;
			if (fast_event_hit)
				rtc_mem[`RSC_ADDR_EVENT][`RSC_BIT_EV_FAST_FLAG] <= 1'b1;
			if (slow_event_hit)
				rtc_mem[`RSC_ADDR_EVENT][`RSC_BIT_EV_SLOW_FLAG] <= 1'b1;
			if (watchdog_overflow)
				rtc_mem[`RSC_ADDR_WATCHDOG][`RSC_BIT_WDT_FLAG] <= 1'b1;
		end
	end

	// Interrupt pin held low while any alarm or event flag stands
	always_ff @(posedge ref_clk) begin
		if (rst)
			irq_n_oe <= 1'b0;
		else
			irq_n_oe <= rtc_mem[`RSC_ADDR_ALARM0_DAY][`RSC_BIT_ALARM_FLAG]
				| rtc_mem[`RSC_ADDR_ALARM1_DAY][`RSC_BIT_ALARM_FLAG]
				| rtc_mem[`RSC_ADDR_EVENT][`RSC_BIT_EV_FAST_FLAG]
				| rtc_mem[`RSC_ADDR_EVENT][`RSC_BIT_EV_SLOW_FLAG];
	end

	// Watchdog pulse, length picked by the pulse-select bit
	logic [11:0] wdo_cnt;
	always_ff @(posedge ref_clk) begin
		if (rst)
			wdo_cnt <= 12'h000;
		else if (watchdog_overflow)
			wdo_cnt <= rtc_mem[`RSC_ADDR_WATCHDOG][`RSC_BIT_WDT_PULSE]
				? 12'(`RSC_WDO_LONG_CYCLES) : 12'(`RSC_WDO_SHORT_CYCLES);
		else if (wdo_cnt != 12'h000)
			wdo_cnt <= wdo_cnt - 12'h001;
	end

	// Side-effect outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			watchdog_clear    <= 1'b0;
			backup_enable_bit <= 1'b0;
		end else begin
			watchdog_clear    <= instr_done & ~wip & (byte_in == `RSC_CMD_WDT_CLEAR);
			backup_enable_bit <= rtc_mem[`RSC_ADDR_BACKUP][`RSC_BIT_BACKUP_EN];
		end
	end

	assign watchdog_pulse_out = 1'b0;
	assign watchdog_pulse_oe  = (wdo_cnt != 12'h000);
	assign irq_n_out          = 1'b0;
	assign standby            = cs_sync[1] & ~wip;
	assign write_busy         = wip;

endmodule

`default_nettype wire

/* verif/rsc_spi_cmd_sva.sv */
/* Checker of the serial command front end, bound to its ports.
   Assumes one ref_clk domain and the constants header on the include path. */
`include "rsc_spi_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module rsc_spi_cmd_sva #(
	parameter int unsigned WRITE_CYCLES = 50
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic so_out,
	input wire logic so_oe,
	// Event inputs
	input wire logic alarm0_match,
	input wire logic alarm1_match,
	input wire logic fast_event_hit,
	input wire logic slow_event_hit,
	input wire logic watchdog_overflow,
	// Outputs watched
	input wire logic watchdog_pulse_oe,
	input wire logic irq_n_oe,
	input wire logic standby,
	input wire logic write_busy,
	input wire logic watchdog_clear
);
	logic        sck_d;
	logic        cs_d;
	logic [3:0]  since_fall;
	logic [3:0]  since_rise;
	logic [11:0] wdo_len;
	logic [17:0] busy_len;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Ages of the last sck fall and cs_n rise, saturating at 15
	always_ff @(posedge ref_clk) begin
		sck_d <= sck;
		cs_d <= cs_n;
		if (rst || (sck_d && !sck))
			since_fall <= rst ? 4'hF : 4'h0;
		else if (since_fall != 4'hF)
			since_fall <= since_fall + 4'h1;
		if (rst || (!cs_d && cs_n))
			since_rise <= rst ? 4'hF : 4'h0;
		else if (since_rise != 4'hF)
			since_rise <= since_rise + 4'h1;
	end

	// Lengths of the open-drain pulse and of the busy period
	always_ff @(posedge ref_clk) begin
		wdo_len <= (watchdog_pulse_oe && !rst) ? wdo_len + 12'h001 : 12'h000;
		busy_len <= (write_busy && !rst) ? busy_len + 18'h0_0001 : 18'h0_0000;
	end

	sequence seq_sel_held;
		!cs_n [*4];
	endsequence
	sequence seq_desel_held;
		cs_n [*4];
	endsequence
	sequence seq_any_event;
		alarm0_match || alarm1_match || fast_event_hit || slow_event_hit;
	endsequence

	chk_sel_wakes: assert property (seq_sel_held |-> !standby)
		else $error("standby while selected");
	chk_busy_awake: assert property (write_busy |-> !standby)
		else $error("standby during write cycle");
	chk_so_hiz: assert property (seq_desel_held |-> !so_oe)
		else $error("serial output driven while deselected");
	chk_so_on_fall: assert property ($changed(so_out) && so_oe |-> since_fall <= 4'h5)
		else $error("serial output changed away from sck fall");
	chk_write_on_rise: assert property ($rose(write_busy) |-> since_rise <= 4'h6)
		else $error("write cycle started without cs_n rise");
	chk_busy_length: assert property ($fell(write_busy) |->
		busy_len >= WRITE_CYCLES - 1 && busy_len <= WRITE_CYCLES + 1)
		else $error("write cycle length wrong");
	chk_wdo_start: assert property (watchdog_overflow |-> ##[1:3] watchdog_pulse_oe)
		else $error("watchdog pulse not started");
	chk_wdo_length: assert property ($fell(watchdog_pulse_oe) |->
		wdo_len == `RSC_WDO_SHORT_CYCLES || wdo_len == `RSC_WDO_LONG_CYCLES)
		else $error("watchdog pulse length wrong");
	chk_irq_raise: assert property (seq_any_event |-> ##[1:2] irq_n_oe)
		else $error("interrupt not raised on event");
	chk_irq_holds: assert property (seq_desel_held ##0 irq_n_oe |=> irq_n_oe)
		else $error("interrupt dropped without a write");
	chk_wclr_pulse: assert property (watchdog_clear |-> !cs_n ##1 !watchdog_clear)
		else $error("watchdog clear pulse wrong");
endmodule
`default_nettype wire

/* verif/rsc_spi_master.sv */
/* SPI master model, mode 0, paced by ref_clk: sck half period is four cycles.
   Assumes the bench resolves the serial output line and calls the tasks. */
`timescale 1ns/1ps
`default_nettype none
module rsc_spi_master (
	// Clock
	input  wire logic       ref_clk,
	// Serial pins
	input  wire logic       so_line,
	output logic            cs_n,
	output logic            sck,
	output logic            si,
	// Received byte and its strobe
	output logic [7:0]      rx_byte,
	output logic            rx_done
);
	// Idle pins; sck stands low between frames
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rx_done = 1'b0;
	end

	// Select, then hold cs_n low through the whole operation
	task automatic sel;
		cs_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	// Release after the last bit; gap lets the device see standby
	task automatic desel;
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask

	// One byte each way, MSB first; data set on sck low, read late in sck high
	task automatic io(input logic [7:0] tx, input logic note);
		for (int i = 7; i >= 0; i--) begin
			si <= tx[i];
			repeat (4) @(posedge ref_clk);
			sck <= 1'b1;
			repeat (4) @(posedge ref_clk);
			rx_byte[i] <= so_line;
			sck <= 1'b0;
		end
		rx_done <= note;
		@(posedge ref_clk);
		rx_done <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* verif/tb_rsc_spi_cmd.sv */
/* Self-checking bench of the serial command front end.
   Assumes package, design, checker and master model compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_rsc_spi_cmd;
	// Long enough that a status read issued right after a commit still sees the busy bit
	localparam int unsigned WCYC = 300;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  ev = 4'h0;
	logic        watchdog_overflow = 1'b0;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        so_out;
	logic        so_oe;
	logic        so_last = 1'b0;
	logic        so_line;
	logic        wdo_oe;
	logic        irq_oe;
	logic        standby;
	logic        write_busy;
	logic        watchdog_clear;
	logic        backup_enable_bit;
	logic [7:0]  rx_byte;
	logic        rx_done;
	logic [7:0]  r [3];
	logic [7:0]  expq [$];
	logic [7:0]  fa [4] = '{8'h0F, 8'h16, 8'h0B, 8'h0B};
	logic [15:0] n;
	int          seed;
	int          cyc = 0;
	int          n_wclr = 0;
	int          n_mismatch = 0;
	int          checks_done = 0;

	rsc_spi_cmd #(.WRITE_CYCLES(WCYC)) i_rsc_spi_cmd (
		.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
		.so_out(so_out), .so_oe(so_oe), .alarm0_match(ev[0]), .alarm1_match(ev[1]),
		.fast_event_hit(ev[2]), .slow_event_hit(ev[3]),
		.watchdog_overflow(watchdog_overflow), .watchdog_pulse_out(),
		.watchdog_pulse_oe(wdo_oe), .irq_n_out(), .irq_n_oe(irq_oe),
		.standby(standby), .write_busy(write_busy), .watchdog_clear(watchdog_clear),
		.backup_enable_bit(backup_enable_bit));
	rsc_spi_master i_rsc_spi_master (.ref_clk(ref_clk), .so_line(so_line), .cs_n(cs_n),
		.sck(sck), .si(si), .rx_byte(rx_byte), .rx_done(rx_done));

	// Clock, and the undriven serial line floating away from its last value
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (so_oe === 1'b1) so_last <= so_out;
	assign so_line = (so_oe === 1'b1) ? so_out : ~so_last;

	task automatic test_done;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic flag(input logic got, input logic exp);
		check({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic cmd(input logic [7:0] c);
		i_rsc_spi_master.sel();
		i_rsc_spi_master.io(c, 1'b0);
		i_rsc_spi_master.desel();
	endtask

	task automatic wr(input logic [7:0] ins, input logic [7:0] a, input logic [7:0] d[$]);
		i_rsc_spi_master.sel();
		i_rsc_spi_master.io(ins, 1'b0);
		i_rsc_spi_master.io(a, 1'b0);
		foreach (d[i]) i_rsc_spi_master.io(d[i], 1'b0);
		i_rsc_spi_master.desel();
	endtask

	// Read: expected bytes are queued before they are clocked out
	task automatic rd(input logic [7:0] ins, input logic [7:0] a, input logic [7:0] e[$]);
		i_rsc_spi_master.sel();
		i_rsc_spi_master.io(ins, 1'b0);
		if (ins != 8'h05) i_rsc_spi_master.io(a, 1'b0);
		foreach (e[i]) begin
			expq.push_back(e[i]);
			i_rsc_spi_master.io(8'h00, 1'b1);
		end
		i_rsc_spi_master.desel();
	endtask

	task automatic wait_idle;
		for (int k = 0; k < 1000 && write_busy !== 1'b0; k++) @(posedge ref_clk);
		flag(write_busy, 1'b0);
	endtask

	// Received bytes against the oldest note; pulse count; run limit
	always @(posedge ref_clk) begin
		if (rx_done === 1'b1)
			check({8'h00, rx_byte}, {8'h00, expq.pop_front()});
		if (watchdog_clear === 1'b1)
			n_wclr++;
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			test_done();
		end
	end

	// Main sequence
	initial begin
		seed = 32'h2e19da28;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		flag(standby, 1'b1);
		flag(so_oe, 1'b0);
		for (int i = 0; i < 3; i++) r[i] = 8'($random(seed));
		wr(8'h12, 8'h1E, '{r[0], r[1], r[2]});
		rd(8'h13, 8'h1E, '{r[0], r[1], r[2]});
		wr(8'h12, 8'h20, '{r[0]});
		wr(8'h12, 8'h5E, '{r[1], r[2]});
		rd(8'h13, 8'h5E, '{r[1], r[2], r[0]});
		wr(8'h12, 8'h60, '{8'hA5});
		rd(8'h13, 8'h60, '{8'h00});
		cmd(8'h54);
		rd(8'h13, 8'h5F, '{8'h00, 8'h00});
		cmd(8'h44);
		check(16'(n_wclr), 16'h0001);
		i_rsc_spi_master.sel();
		i_rsc_spi_master.io(8'hFF, 1'b0);
		i_rsc_spi_master.io(8'h00, 1'b0);
		flag(so_oe, 1'b0);
		i_rsc_spi_master.desel();
		rd(8'h05, 8'h00, '{8'h00});
		cmd(8'h06);
		rd(8'h05, 8'h00, '{8'h02});
		cmd(8'h04);
		rd(8'h05, 8'h00, '{8'h00});
		wr(8'h02, 8'h10, '{r[0]});
		flag(write_busy, 1'b0);
		cmd(8'h06);
		wr(8'h02, 8'h06, '{r[0], r[1], r[2]});
		flag(write_busy, 1'b1);
		flag(standby, 1'b0);
		rd(8'h05, 8'h00, '{8'h01});
		wait_idle();
		rd(8'h03, 8'h06, '{r[0], r[1]});
		rd(8'h03, 8'h00, '{r[2]});
		cmd(8'h14);
		cmd(8'h06);
		wr(8'h32, 8'h03, '{r[1]});
		wait_idle();
		rd(8'h33, 8'h03, '{r[1]});
		wr(8'h12, 8'h04, '{8'h08});
		flag(backup_enable_bit, 1'b1);
		// Each interrupt source raised, then its flag cleared by a write
		for (int i = 0; i < 4; i++) begin
			ev[i] <= 1'b1;
			@(posedge ref_clk);
			ev <= 4'h0;
			repeat (3) @(posedge ref_clk);
			flag(irq_oe, 1'b1);
			wr(8'h12, fa[i], '{8'h00});
			flag(irq_oe, 1'b0);
		end
		// Both watchdog pulse lengths, chosen by bit 4 of 0Ah
		for (int i = 0; i < 2; i++) begin
			wr(8'h12, 8'h0A, '{i ? 8'h10 : 8'h00});
			watchdog_overflow <= 1'b1;
			@(posedge ref_clk);
			watchdog_overflow <= 1'b0;
			n = 16'h0000;
			repeat (3000) @(posedge ref_clk) if (wdo_oe === 1'b1) n++;
			check(n, i ? 16'h0800 : 16'h0100);
		end
		test_done();
	end
endmodule

bind rsc_spi_cmd rsc_spi_cmd_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_rsc_spi_cmd_sva (
	.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .so_out(so_out),
	.so_oe(so_oe), .alarm0_match(alarm0_match), .alarm1_match(alarm1_match),
	.fast_event_hit(fast_event_hit), .slow_event_hit(slow_event_hit),
	.watchdog_overflow(watchdog_overflow), .watchdog_pulse_oe(watchdog_pulse_oe),
	.irq_n_oe(irq_n_oe), .standby(standby), .write_busy(write_busy),
	.watchdog_clear(watchdog_clear));
`default_nettype wire
